// *** hw/event_mask_map.vh ***
// Register indices, reset values and event code constants for event masking
`ifndef EVENT_MASK_MAP_VH
`define EVENT_MASK_MAP_VH
// Register indices on the host port
`define REG_SYS 2'h0
`define REG_THERM 2'h1
`define REG_OVC 2'h2
`define REG_EARTH 2'h3
// Reset values of the masks
`define RST_SYS 6'h01
`define RST_THERM 14'h1054
`define RST_OVC 12'h555
`define RST_EARTH 12'h155
// Event code bases
`define CODE_SYS_FIXED 6'h01
`define CODE_SYS_MASK 6'h1f
`define CODE_THERM 6'h01
`define CODE_OVC 6'h0f
`define CODE_EARTH 6'h1b
`define CODE_RESTART 6'h32
`define CODE_OVERFLOW 6'h33
// Restart inhibit pair within the thermal group
`define BIT_RI_SET 4'hc
`define BIT_RI_CLR 4'hd
// Buffer
`define BUF_DEPTH 7'h64
`define READ_BATCH 3'h5
`endif

// *** hw/event_mask_unit.v ***
// Event code generation, masking and event buffer for the protection relay
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Channel 0 E1 to E7 always reported
// - Thermal level write via link emits E7
// - Channel 0 E31 to E36 maskable by weight
// - System mask resets to 1
// - Channel 1 E1 to E14 weights 1..8192
// - Thermal mask resets to 4180
// - Restart inhibit from three sources raises E13
// - Start-stage events suppressed during motor start-up
// - Channel 1 E15 to E26 weights 1..2048
// - Overcurrent mask resets to 1365
// - Channel 1 E27 to E38 weights 1..2048
// - Earth and unbalance mask resets to 341
// - Maskable event stored only when bit set
// - Restart and overflow kept until clear command
// - Buffer holds 100, read five at a time
`include "event_mask_map.vh"
module event_mask_unit (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Event sources, one-cycle pulses; the inhibit and motor_starting inputs are levels
  input wire [5:0] sys_fixed_ev,
  input wire thermal_level_written,
  input wire [5:0] sys_mask_ev,
  input wire [11:0] therm_ev,
  input wire thermal_inhibit_over,
  input wire start_counter_full,
  input wire ext_inhibit,
  input wire [11:0] ovc_ev,
  input wire [11:0] earth_ev,
  input wire motor_starting,
  input wire relay_restarted,
  // Mask register port
  input wire reg_wr,
  input wire [1:0] reg_addr,
  input wire [13:0] reg_wdata,
  output reg [13:0] reg_rdata,
  // Host read commands
  input wire read_batch,
  input wire reread_batch,
  input wire clear_sticky,
  // Event output
  output reg ev_valid,
  output reg [1:0] ev_channel,
  output reg [5:0] ev_code,
  output reg [6:0] ev_count,
  output reg restart_flag,
  output reg overflow_flag
);

  // Reset release through two flops
  reg rst_s1_r;
  reg rst_s2_r;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire rst_n = rst_s2_r;

  // Masks
  reg [5:0] sys_en_r;
  reg [13:0] therm_en_r;
  reg [11:0] ovc_en_r;
  reg [11:0] earth_en_r;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sys_en_r <= `RST_SYS;
      therm_en_r <= `RST_THERM;
      ovc_en_r <= `RST_OVC;
      earth_en_r <= `RST_EARTH;
    end else if (reg_wr) begin
      case (reg_addr)
        `REG_SYS: sys_en_r <= reg_wdata[5:0];
        `REG_THERM: therm_en_r <= reg_wdata;
        `REG_OVC: ovc_en_r <= reg_wdata[11:0];
        `REG_EARTH: earth_en_r <= reg_wdata[11:0];
        default: sys_en_r <= sys_en_r;
      endcase
    end
  end

  // Register readback
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 14'h0000;
    end else begin
      case (reg_addr)
        `REG_SYS: reg_rdata <= {8'h00, sys_en_r};
        `REG_THERM: reg_rdata <= therm_en_r;
        `REG_OVC: reg_rdata <= {2'h0, ovc_en_r};
        default: reg_rdata <= {2'h0, earth_en_r};
      endcase
    end
  end

  // Restart inhibit level and its edges
  reg inhibit_r;
  wire inhibit_now = thermal_inhibit_over | start_counter_full | ext_inhibit;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      inhibit_r <= 1'b0;
    end else begin
      inhibit_r <= inhibit_now;
    end
  end

  // Start-stage bits: thermal 2,3; ovc 0,1,4,5,8,9; earth 0,1,4,5
  // Suppression lasts as long as the start-up level stands
  wire [13:0] therm_raw = {~inhibit_now & inhibit_r, inhibit_now & ~inhibit_r, therm_ev};
  wire [13:0] therm_sup = motor_starting ? 14'h000c : 14'h0000;
  wire [11:0] ovc_sup = motor_starting ? 12'h333 : 12'h000;
  wire [11:0] earth_sup = motor_starting ? 12'h033 : 12'h000;

  // Masked requests per group; suppression only touches start-stage bits
  // A mask write takes effect from the next clock, never on queued events
  wire [6:0] fixed_req = {thermal_level_written, sys_fixed_ev};
  wire [5:0] sys_req = sys_mask_ev & sys_en_r;
  wire [13:0] therm_req = therm_raw & therm_en_r & ~therm_sup;
  wire [11:0] ovc_req = ovc_ev & ovc_en_r & ~ovc_sup;
  wire [11:0] earth_req = earth_ev & earth_en_r & ~earth_sup;
  // Packed vector: 0..6 fixed, 7..12 sys, 13..26 therm, 27..38 ovc, 39..50 earth
  wire [50:0] req = {earth_req, ovc_req, therm_req, sys_req, fixed_req};

  // Pending latches: events arriving together are queued, clear of the picked bit wins
  reg [50:0] pend_r;
  wire [50:0] all_pend = pend_r | req;
  reg [5:0] pick;
  reg found;
  integer i;
  always @* begin
    pick = 6'h00;
    found = 1'b0;
    for (i = 50; i >= 0; i = i - 1) begin
      if (all_pend[i]) begin
        pick = i[5:0];
        found = 1'b1;
      end
    end
  end

  // Map vector index to channel and code
  function [7:0] map_code;
    input [5:0] idx;
    begin
      if (idx < 6'd7)
        map_code = {2'h0, idx + `CODE_SYS_FIXED};
      else if (idx < 6'd13)
        map_code = {2'h0, idx - 6'd7 + `CODE_SYS_MASK};
      else if (idx < 6'd27)
        map_code = {2'h1, idx - 6'd13 + `CODE_THERM};
      else if (idx < 6'd39)
        map_code = {2'h1, idx - 6'd27 + `CODE_OVC};
      else
        map_code = {2'h1, idx - 6'd39 + `CODE_EARTH};
    end
  endfunction

  // Event buffer, circular, with read and reread pointers
  reg [7:0] mem [0:127];
  reg [6:0] wp_r;
  reg [6:0] rp_r;
  reg [6:0] cnt_r;
  reg [6:0] last_rp_r;
  reg [2:0] out_left_r;
  reg [6:0] out_ptr_r;
  wire full = (cnt_r == `BUF_DEPTH);
  wire store = found & ~full;
  wire [7:0] code_w = map_code(pick);

  function [6:0] wrap;
    input [6:0] p;
    begin
      wrap = (p == `BUF_DEPTH - 7'h01) ? 7'h00 : p + 7'h01;
    end
  endfunction

  // Clear the serviced request; a new event on any other bit keeps its bit set
  // With the buffer full the picked event is dropped, not held, so a
  // burst during overflow cannot replay itself once the host reads
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 51'h0;
    end else begin
      pend_r <= all_pend & ~((found ? 51'h1 : 51'h0) << pick);
    end
  end

  always @(posedge clock) begin
    if (store)
      mem[wp_r] <= code_w;
  end

  // Batch readout control; commands arriving mid-batch are ignored
  // The fill level drops at the start of a batch so new events can use the space
  reg [2:0] last_len_r;
  wire busy = (out_left_r != 3'h0);
  wire start_rd = (read_batch | reread_batch) & ~busy;
  wire take_new = start_rd & read_batch; // Plain read wins over reread
  wire take_old = start_rd & ~read_batch;
  wire [6:0] rd_cnt = (cnt_r > {4'h0, `READ_BATCH}) ? {4'h0, `READ_BATCH} : cnt_r;
  // Read pointer advance with wrap at the buffer depth
  wire [6:0] rp_sum = rp_r + rd_cnt;
  wire [6:0] rp_adv = (rp_sum >= `BUF_DEPTH) ? rp_sum - `BUF_DEPTH : rp_sum;

  // Write pointer follows every stored event
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= 7'h00;
    end else if (store) begin
      wp_r <= wrap(wp_r);
    end
  end

  // Read pointer and the batch kept for a reread
  // A reread after the buffer wraps may show newer events; the host
  // is expected to reread soon after a failed read
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rp_r <= 7'h00;
      last_rp_r <= 7'h00;
      last_len_r <= 3'h0;
    end else if (take_new) begin
      rp_r <= rp_adv;
      last_rp_r <= rp_r;
      last_len_r <= rd_cnt[2:0];
    end
  end

  // Fill level: one in per stored event, a whole batch out per plain read
  // Never passes the depth, since nothing is stored while full
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 7'h00;
    end else if (take_new) begin
      cnt_r <= cnt_r - rd_cnt + {6'h00, store};
    end else begin
      cnt_r <= cnt_r + {6'h00, store};
    end
  end

  // Output sequencer, one event per clock, oldest first
  // ev_valid stands one cycle per event, up to five in a row
  // Reread replays the previous batch from where it began
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_left_r <= 3'h0;
      out_ptr_r <= 7'h00;
      ev_valid <= 1'b0;
      ev_channel <= 2'h0;
      ev_code <= 6'h00;
      ev_count <= 7'h00;
    end else begin
      ev_count <= cnt_r;
      ev_valid <= busy;
      if (take_new) begin
        out_ptr_r <= rp_r;
        out_left_r <= rd_cnt[2:0];
      end else if (take_old) begin
        out_ptr_r <= last_rp_r;
        out_left_r <= last_len_r;
      end else if (busy) begin
        out_ptr_r <= wrap(out_ptr_r);
        out_left_r <= out_left_r - 3'h1;
      end
      if (busy) begin
        ev_channel <= mem[out_ptr_r][7:6];
        ev_code <= mem[out_ptr_r][5:0];
      end
    end
  end

  // Restart flag; only the clear command resets it, and set wins
  // The restart itself is a flag, not a buffered entry
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      restart_flag <= 1'b0;
    end else begin
      restart_flag <= relay_restarted | (restart_flag & ~clear_sticky);
    end
  end

  // Overflow flag: an event found with the buffer full is dropped
  // Dropping keeps the oldest events, which the host has not seen yet
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      overflow_flag <= 1'b0;
    end else begin
      overflow_flag <= (found & full) | (overflow_flag & ~clear_sticky);
    end
  end

endmodule
`default_nettype wire

// *** bench/inhibit_sources.sv ***
// Model of the three restart inhibit sources
`timescale 1ns/1ps
`default_nettype none
module inhibit_sources (
  // Clock and bench request
  input wire logic clock,
  input wire logic [1:0] src_sel,
  input wire logic src_on,
  // Inhibit levels, one source active at a time
  output logic thermal_inhibit_over,
  output logic start_counter_full,
  output logic ext_inhibit
);
  // Registered so levels move just after an edge
  always @(posedge clock) begin
    thermal_inhibit_over <= src_on && src_sel == 2'h0;
    start_counter_full <= src_on && src_sel == 2'h1;
    ext_inhibit <= src_on && src_sel == 2'h2;
  end
endmodule
`default_nettype wire

// *** bench/event_mask_unit_assertions.sv ***
// Port assertions for the event masking unit
`timescale 1ns/1ps
`default_nettype none
module event_mask_unit_assertions (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Watched ports
  input wire logic [5:0] sys_fixed_ev,
  input wire logic relay_restarted,
  input wire logic clear_sticky,
  input wire logic read_batch,
  input wire logic reread_batch,
  input wire logic ev_valid,
  input wire logic [1:0] ev_channel,
  input wire logic [5:0] ev_code,
  input wire logic [6:0] ev_count,
  input wire logic restart_flag,
  input wire logic overflow_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_fixed; sys_fixed_ev != 6'h00 && ev_count == 7'h00 |-> ##[1:3] ev_count != 7'h00; endproperty
  a_fixed: assert property (p_fixed) else $error("fixed event not stored");
  property p_chan; ev_valid |-> ev_channel <= 2'h1 && ev_code != 6'h00; endproperty
  a_chan: assert property (p_chan) else $error("bad channel or code");
  property p_code; ev_valid && ev_channel == 2'h1 |-> ev_code <= 6'h26; endproperty
  a_code: assert property (p_code) else $error("channel 1 code out of range");
  property p_cap; ev_count <= 7'h64; endproperty
  a_cap: assert property (p_cap) else $error("buffer above capacity");
  property p_batch;
    read_batch && !ev_valid && !$past(reread_batch) && ev_count >= 7'h05 |=> ##1 ev_valid [*5];
  endproperty
  a_batch: assert property (p_batch) else $error("batch not five long");
  property p_burst; ev_valid [*5] |=> !ev_valid; endproperty
  a_burst: assert property (p_burst) else $error("batch longer than five");
  property p_restart; relay_restarted |=> restart_flag; endproperty
  a_restart: assert property (p_restart) else $error("restart flag not set");
  property p_hold; restart_flag && !clear_sticky |=> restart_flag; endproperty
  a_hold: assert property (p_hold) else $error("restart flag lost without clear");
  property p_clear; clear_sticky && !relay_restarted |=> !restart_flag; endproperty
  a_clear: assert property (p_clear) else $error("restart flag not cleared");
  property p_overflow;
    ev_count == 7'h64 && !$past(read_batch) && sys_fixed_ev != 6'h00 |=> overflow_flag;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged");
  property p_solicited;
    $rose(ev_valid) |-> $past(read_batch, 2) || $past(reread_batch, 2);
  endproperty
  a_solicited: assert property (p_solicited) else $error("output without read command");
  property p_chan0;
    ev_valid && ev_channel == 2'h0 |-> ev_code < 6'h08 || (ev_code > 6'h1e && ev_code < 6'h25);
  endproperty
  a_chan0: assert property (p_chan0) else $error("channel 0 code out of range");
  property p_empty; read_batch && ev_count == 7'h00 && !ev_valid |=> !ev_valid; endproperty
  a_empty: assert property (p_empty) else $error("output from empty buffer");
endmodule
bind event_mask_unit event_mask_unit_assertions chk_i (.clock, .nrst, .sys_fixed_ev,
  .relay_restarted, .clear_sticky, .read_batch, .reread_batch, .ev_valid, .ev_channel,
  .ev_code, .ev_count, .restart_flag, .overflow_flag);
`default_nettype wire

// *** bench/tb.sv ***
// Self-checking bench for the event masking unit
`timescale 1ns/1ps
`default_nettype none
`include "event_mask_map.vh"
module tb;
  reg clock = 0, nrst = 0, thermal_level_written = 0, motor_starting = 0, relay_restarted = 0;
  reg [5:0] sys_fixed_ev = 0, sys_mask_ev = 0;
  reg [11:0] therm_ev = 0, ovc_ev = 0, earth_ev = 0;
  reg reg_wr = 0, read_batch = 0, reread_batch = 0, clear_sticky = 0, src_on = 0;
  reg [1:0] reg_addr = 0, src_sel = 0;
  reg [13:0] reg_wdata = 0, m;
  reg [6:0] exp_cnt = 0;
  wire [13:0] reg_rdata;
  wire ev_valid, restart_flag, overflow_flag, thermal_inhibit_over, start_counter_full, ext_inhibit;
  wire [1:0] ev_channel;
  wire [5:0] ev_code;
  wire [6:0] ev_count;
  integer error_cnt = 0, num_checks = 0, seed = 99, i, n;
  // Free-running bench clock
  always #50 clock = ~clock;
  event_mask_unit dut (.clock, .nrst, .sys_fixed_ev, .thermal_level_written, .sys_mask_ev,
    .therm_ev, .thermal_inhibit_over, .start_counter_full, .ext_inhibit, .ovc_ev, .earth_ev,
    .motor_starting, .relay_restarted, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
    .read_batch, .reread_batch, .clear_sticky, .ev_valid, .ev_channel, .ev_code, .ev_count,
    .restart_flag, .overflow_flag);
  inhibit_sources src (.clock, .src_sel, .src_on, .thermal_inhibit_over, .start_counter_full,
    .ext_inhibit);
  task chk(input [13:0] got, input [13:0] want);
    begin
      num_checks = num_checks + 1;
      if (got !== want) begin
        error_cnt = error_cnt + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
    end
  endtask
  task close_out;
    begin
      if (error_cnt == 0 && num_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(negedge clock);
  endtask
  // Fill level left after a plain read of up to five events
  function [6:0] after_read(input [6:0] c);
    after_read = c > 7'h05 ? c - 7'h05 : 7'h00;
  endfunction
  // Host clear command for the sticky flags
  task clear_flags;
    begin
      clear_sticky = 1;
      cyc(1);
      clear_sticky = 0;
      cyc(2);
    end
  endtask
  task wr(input [1:0] a, input [13:0] d);
    begin
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1;
      cyc(1);
      reg_wr = 0;
    end
  endtask
  task rd(input [1:0] a, input [13:0] w);
    begin
      reg_addr = a;
      cyc(2);
      chk(reg_rdata, w);
    end
  endtask
  // Pulses last one cycle; a fixed wait lets the store land
  task fire(input stored);
    begin
      cyc(1);
      {sys_fixed_ev, thermal_level_written, sys_mask_ev, therm_ev, ovc_ev, earth_ev} = 0;
      relay_restarted = 0;
      cyc(3);
      exp_cnt = exp_cnt + stored;
      chk(ev_count, exp_cnt);
    end
  endtask
  // Bounded wait for the first event of a batch
  task batch(input [7:0] want, input again);
    integer k;
    begin
      read_batch = ~again;
      reread_batch = again;
      cyc(1);
      read_batch = 0;
      reread_batch = 0;
      for (k = 0; k < 9 && ev_valid !== 1'b1; k = k + 1)
        cyc(1);
      if (k == 9) begin
        error_cnt = error_cnt + 1;
        close_out;
      end
      if (want != 0)
        chk({ev_channel, ev_code}, want);
      cyc(7);
      if (!again)
        exp_cnt = after_read(exp_cnt);
      chk(ev_count, exp_cnt);
    end
  endtask
  initial begin
    cyc(8);
    nrst = 1;
    cyc(4);
    rd(`REG_SYS, 14'h0001);
    rd(`REG_THERM, 14'h1054);
    rd(`REG_OVC, 14'h0555);
    rd(`REG_EARTH, 14'h0155);
    wr(`REG_SYS, 14'h0000);
    for (i = 0; i < 6; i = i + 1) begin
      sys_fixed_ev = 6'h01 << i;
      fire(1);
      sys_mask_ev = 6'h01 << i;
      fire(0);
    end
    thermal_level_written = 1;
    fire(1);
    wr(`REG_SYS, 14'h0020);
    sys_mask_ev = 6'h20;
    fire(1);
    relay_restarted = 1;
    fire(0);
    batch(8'h01, 0);
    batch(8'h01, 1);
    chk(restart_flag, 1'b1);
    // Random masks per channel 1 group, event bits 0 to 11 of each group pulsed
    for (n = 1; n < 4; n = n + 1) begin
      m = 14'($random(seed));
      wr(n[1:0], m);
      rd(n[1:0], n == 1 ? m : {2'h0, m[11:0]});
      for (i = 0; i < 12; i = i + 1) begin
        therm_ev = n == 1 ? 12'h001 << i : 12'h000;
        ovc_ev = n == 2 ? 12'h001 << i : 12'h000;
        earth_ev = n == 3 ? 12'h001 << i : 12'h000;
        fire(m[i]);
      end
    end
    wr(`REG_OVC, 14'h0fff);
    motor_starting = 1;
    ovc_ev = 12'h001;
    fire(0);
    ovc_ev = 12'h004;
    fire(1);
    earth_ev = 12'h030;
    fire(0);
    earth_ev = 12'h004;
    fire(m[2]);
    motor_starting = 0;
    wr(`REG_THERM, 14'h1054);
    for (i = 0; i < 3; i = i + 1) begin
      src_sel = i[1:0];
      src_on = 1;
      fire(1);
      src_on = 0;
      fire(0);
    end
    clear_flags;
    chk(restart_flag, 1'b0);
    for (n = 0; n < 30 && exp_cnt != 0; n = n + 1)
      batch(0, 0);
    for (i = 0; i < 101; i = i + 1) begin
      sys_fixed_ev = 6'h01;
      fire(i < 100);
    end
    chk(overflow_flag, 1'b1);
    batch(8'h01, 0);
    clear_flags;
    chk(overflow_flag, 1'b0);
    close_out;
  end
endmodule
`default_nettype wire
